// file: smc_defs.vh
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

// ********************************************************
// word format
// ********************************************************
`define SMC_WORD_W 24
`define SMC_SEL_MSB 2
`define SMC_SEL_LSB 0

// ********************************************************
// select codes
// ********************************************************
`define SMC_SEL_DITHER 3'h3
`define SMC_SEL_PUMP 3'h4
`define SMC_SEL_LOPATH 3'h5
`define SMC_SEL_OSC 3'h6

// ********************************************************
// reset values
// ********************************************************
`define SMC_RST_DITHER 24'h10000B
`define SMC_RST_PUMP 24'h12A7E4
`define SMC_RST_LOPATH 24'h0000E5
`define SMC_RST_OSC 24'h1E2106

// ********************************************************
// dither control fields
// ********************************************************
`define SMC_DIT_RESTART_MSB 19
`define SMC_DIT_RESTART_LSB 3
`define SMC_DIT_ENABLE_BIT 20
`define SMC_DIT_MAG_MSB 23
`define SMC_DIT_MAG_LSB 21

// ********************************************************
// charge pump and reference fields
// ********************************************************
`define SMC_CP_MON_MSB 9
`define SMC_CP_MON_LSB 7
`define SMC_CP_CUR_MSB 11
`define SMC_CP_CUR_LSB 10
`define SMC_CP_OFS_MSB 16
`define SMC_CP_OFS_LSB 12
`define SMC_CP_POL_BIT 17
`define SMC_CP_PUMP_SET_RESISTOR_BIT 18
`define SMC_CP_REF_MSB 20
`define SMC_CP_REF_LSB 19
`define SMC_MON_LOCK_SEL 3'h7

// ********************************************************
// lo path fields
// ********************************************************
`define SMC_LO_DRV_BIT 3
`define SMC_LO_EXT_BIT 4
`define SMC_LO_DIV_BIT 5
`define SMC_LO_MBIAS_BIT 6
`define SMC_LO_MOUT_BIT 7

// ********************************************************
// oscillator fields
// ********************************************************
`define SMC_OSC_BAND_MSB 8
`define SMC_OSC_BAND_LSB 3
`define SMC_OSC_BSRC_BIT 9
`define SMC_OSC_AMP_MSB 15
`define SMC_OSC_AMP_LSB 10
`define SMC_OSC_VCOEN_MSB 19
`define SMC_OSC_VCOEN_LSB 17
`define SMC_OSC_CPEN_BIT 20
`define SMC_OSC_PLL_MSB 20
`define SMC_OSC_PLL_LSB 17

`endif

// file: smc_shift_in.v
`default_nettype none

module smc_shift_in #(
    parameter WORD_W = 24
) (
    input wire clock_i,
    input wire srst_i,
    input wire sclk_i,
    input wire sdata_i,
    input wire sle_i,
    output wire [WORD_W-1:0] word_o,
    output wire load_o
);

    reg [WORD_W-1:0] shift_q;
    reg sclk_q;
    reg sle_q;
    reg load_q;

    // ********************************************************
    // shifter: msb first, bits taken on sclk rise while le low
    // ********************************************************
    // only the last WORD_W bits before the le rise count; extra
    // leading bits fall off the top
    always @(posedge clock_i) begin
        if (srst_i) begin
            shift_q <= {WORD_W{1'b0}};
            sclk_q <= 1'b0;
            // le idles high; resetting to that level keeps a false load off the first edge
            sle_q <= 1'b1;
            load_q <= 1'b0;
        end else begin
            sclk_q <= sclk_i;
            sle_q <= sle_i;
            load_q <= sle_i & ~sle_q;
            if (sclk_i && !sclk_q && !sle_i) begin
                shift_q <= {shift_q[WORD_W-2:0], sdata_i};
            end
        end
    end

    assign word_o = shift_q;
    assign load_o = load_q;

endmodule // smc_shift_in

`default_nettype wire

// file: smc_lo_port.v
`default_nettype none

module smc_lo_port (
    input wire clock_i,
    input wire srst_i,
    input wire lo_port_select_pin_i,
    input wire lo_divide_select_i,
    input wire lo_external_input_select_i,
    input wire lo_output_driver_enable_i,
    output reg lo_port_input_o,
    output reg lo_port_output_o,
    output reg lo_port_doubled_o
);

    wire drive_out;
    wire as_input;

    // ********************************************************
    // port mode decode
    // ********************************************************
    assign as_input = !lo_port_select_pin_i && lo_external_input_select_i
        && !lo_output_driver_enable_i;
    // combinations outside the table fall back to a disabled output
    assign drive_out = !lo_external_input_select_i
        && (lo_port_select_pin_i || lo_output_driver_enable_i);

    always @(posedge clock_i) begin
        if (srst_i) begin
            lo_port_input_o <= 1'b0;
            lo_port_output_o <= 1'b0;
            lo_port_doubled_o <= 1'b0;
        end else begin
            lo_port_input_o <= as_input;
            lo_port_output_o <= drive_out;
            lo_port_doubled_o <= as_input | (drive_out & lo_divide_select_i);
        end
    end

endmodule // smc_lo_port

`default_nettype wire

// file: smc_config_regs.v
// Behaviour
// - select code 011 stores the word in dither control, reset 0x10000B.
// - dither enabled at reset; magnitude resets to 15, 1 recommended.
// - dither restart field takes 0 to 2^17-1; 1 typical.
// - select code 100 stores the word in charge pump register, reset 0x12A7E4.
// - bits 11:10 pick pump current; bit 18 picks internal or resistor reference.
// - bits 16:12 set phase offset in 22.5 degree steps, reset 10.
// - bit 17 sets phase offset polarity.
// - reference path scales reference by two, one, half or quarter.
// - monitor pin shows a selected signal, lock detect after reset.
// - select code 101 stores the word in lo path register, reset 0x0000E5.
// - separate enables for whole modulator bias and modulator output stage.
// - pin low, ext set, driver clear gives doubled input; pin low with both clear disables.
// - output carries doubled lo if divide bit set, else undivided lo.
// - select code 110 stores the word in oscillator register, reset 0x1E2106.
// - bit 9 picks calibrated band or manual band in bits 8:3.
// - oscillator amplitude 0 to 63, reset 8, 63 recommended.
// - enables for oscillators and charge pump; pump enabled after reset.
`include "smc_defs.vh"
`default_nettype none

module smc_config_regs #(
    parameter WORD_W = `SMC_WORD_W,
    parameter MON_W = 8
) (
    input wire clock_i,
    input wire srst_i,
    // serial programming port
    input wire sclk_i,
    input wire sdata_i,
    input wire sle_i,
    // device side inputs
    input wire lo_port_select_pin_i,
    input wire [5:0] cal_band_i,
    input wire [MON_W-1:0] monitor_source_i,
    // dither
    output wire dither_enable_o,
    output wire [2:0] dither_magnitude_o,
    output wire [16:0] dither_restart_o,
    // charge pump and reference
    output wire [1:0] pump_current_o,
    output wire pump_set_resistor_o,
    output wire [4:0] phase_offset_o,
    output wire phase_offset_negative_o,
    output wire [1:0] reference_scale_o,
    output wire [2:0] monitor_select_o,
    output reg monitor_output_pin_o,
    // lo path and modulator
    output wire modulator_bias_enable_o,
    output wire modulator_output_enable_o,
    output wire lo_port_input_o,
    output wire lo_port_output_o,
    output wire lo_port_doubled_o,
    // oscillator
    output reg [5:0] vco_band_o,
    output wire band_source_select_o,
    output wire [5:0] vco_amplitude_o,
    output wire [2:0] vco_enable_o,
    output wire pump_enable_o,
    output wire pll_powered_down_o
);

    // ********************************************************
    // serial word capture
    // ********************************************************
    wire [WORD_W-1:0] word;
    wire load;
    wire [2:0] sel;

    smc_shift_in #(
        .WORD_W(WORD_W)
    ) u_shift (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .sclk_i(sclk_i),
        .sdata_i(sdata_i),
        .sle_i(sle_i),
        .word_o(word),
        .load_o(load)
    );

    assign sel = word[`SMC_SEL_MSB:`SMC_SEL_LSB];

    // ********************************************************
    // register bank
    // ********************************************************
    reg [WORD_W-1:0] dither_q;
    reg [WORD_W-1:0] pump_q;
    reg [WORD_W-1:0] lopath_q;
    reg [WORD_W-1:0] osc_q;

    // each register changes only on its own select code; the other
    // codes (0 to 2, 7) belong to registers held elsewhere
    always @(posedge clock_i) begin
        if (srst_i) begin
            dither_q <= `SMC_RST_DITHER;
            pump_q <= `SMC_RST_PUMP;
            lopath_q <= `SMC_RST_LOPATH;
            osc_q <= `SMC_RST_OSC;
        end else if (load) begin
            case (sel)
                `SMC_SEL_DITHER: begin
                    dither_q <= word;
                end
                `SMC_SEL_PUMP: begin
                    pump_q <= word;
                end
                `SMC_SEL_LOPATH: begin
                    lopath_q <= word;
                end
                `SMC_SEL_OSC: begin
                    osc_q <= word;
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************************************
    // dither fields
    // ********************************************************
    // magnitude code 0 stands for the reset magnitude of 15
    assign dither_enable_o = dither_q[`SMC_DIT_ENABLE_BIT];
    assign dither_magnitude_o = dither_q[`SMC_DIT_MAG_MSB:`SMC_DIT_MAG_LSB];
    assign dither_restart_o = dither_q[`SMC_DIT_RESTART_MSB:`SMC_DIT_RESTART_LSB];

    // ********************************************************
    // charge pump and reference fields
    // ********************************************************
    assign pump_current_o = pump_q[`SMC_CP_CUR_MSB:`SMC_CP_CUR_LSB];
    assign pump_set_resistor_o = pump_q[`SMC_CP_PUMP_SET_RESISTOR_BIT];
    assign phase_offset_o = pump_q[`SMC_CP_OFS_MSB:`SMC_CP_OFS_LSB];
    assign phase_offset_negative_o = pump_q[`SMC_CP_POL_BIT];
    assign reference_scale_o = pump_q[`SMC_CP_REF_MSB:`SMC_CP_REF_LSB];
    assign monitor_select_o = pump_q[`SMC_CP_MON_MSB:`SMC_CP_MON_LSB];

    // ********************************************************
    // monitor pin
    // ********************************************************
    // registered so the pin does not glitch while the select changes
    always @(posedge clock_i) begin
        if (srst_i) begin
            monitor_output_pin_o <= 1'b0;
        end else begin
            monitor_output_pin_o <= monitor_source_i[monitor_select_o];
        end
    end

    // ********************************************************
    // lo path and modulator
    // ********************************************************
    assign modulator_bias_enable_o = lopath_q[`SMC_LO_MBIAS_BIT];
    assign modulator_output_enable_o = lopath_q[`SMC_LO_MOUT_BIT];

    smc_lo_port u_lo (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .lo_port_select_pin_i(lo_port_select_pin_i),
        .lo_divide_select_i(lopath_q[`SMC_LO_DIV_BIT]),
        .lo_external_input_select_i(lopath_q[`SMC_LO_EXT_BIT]),
        .lo_output_driver_enable_i(lopath_q[`SMC_LO_DRV_BIT]),
        .lo_port_input_o(lo_port_input_o),
        .lo_port_output_o(lo_port_output_o),
        .lo_port_doubled_o(lo_port_doubled_o)
    );

    // ********************************************************
    // oscillator fields
    // ********************************************************
    assign band_source_select_o = osc_q[`SMC_OSC_BSRC_BIT];
    assign vco_amplitude_o = osc_q[`SMC_OSC_AMP_MSB:`SMC_OSC_AMP_LSB];
    assign vco_enable_o = osc_q[`SMC_OSC_VCOEN_MSB:`SMC_OSC_VCOEN_LSB];
    assign pump_enable_o = osc_q[`SMC_OSC_CPEN_BIT];
    // all four enables clear means the synthesizer is off
    assign pll_powered_down_o = ~|osc_q[`SMC_OSC_PLL_MSB:`SMC_OSC_PLL_LSB];

    // calibration result may change at any time, so the band is registered
    always @(posedge clock_i) begin
        if (srst_i) begin
            vco_band_o <= 6'h00;
        end else if (band_source_select_o) begin
            vco_band_o <= osc_q[`SMC_OSC_BAND_MSB:`SMC_OSC_BAND_LSB];
        end else begin
            vco_band_o <= cal_band_i;
        end
    end

endmodule // smc_config_regs

`default_nettype wire

// file: smc_assertions.sv
`default_nettype none
// ********************************
// port checker
// ********************************
module smc_assertions #(
    parameter int WORD_W = 24,
    parameter int MON_W = 8
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic sle_i,
    input wire logic lo_port_select_pin_i,
    input wire logic [5:0] cal_band_i,
    input wire logic [MON_W-1:0] monitor_source_i,
    input wire logic [2:0] monitor_select_o,
    input wire logic monitor_output_pin_o,
    input wire logic lo_port_input_o,
    input wire logic lo_port_output_o,
    input wire logic lo_port_doubled_o,
    input wire logic [5:0] vco_band_o,
    input wire logic band_source_select_o,
    input wire logic [2:0] vco_enable_o,
    input wire logic pump_enable_o,
    input wire logic pll_powered_down_o,
    input wire logic [16:0] dither_restart_o,
    input wire logic [4:0] phase_offset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mon_q;
    always_ff @(posedge clock_i) begin
        mon_q <= monitor_source_i[monitor_select_o];
    end
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    // derived flops settle two edges after reset, so reset edges are kept out of the window
    a_pll_down: assert property (pll_powered_down_o == (vco_enable_o == 3'h0 && !pump_enable_o))
        else $error("pll power down flag wrong");
    a_mon_follow: assert property (!$past(srst_i) && !$past(srst_i, 2) |-> monitor_output_pin_o == mon_q)
        else $error("monitor pin not the selected source");
    a_hold_no_load: assert property (!$past(sle_i, 2) && !$past(srst_i) && !$past(srst_i, 2)
        |-> $stable({dither_restart_o, phase_offset_o, vco_enable_o, band_source_select_o}))
        else $error("register changed without a load");
    a_band_cal: assert property (!$past(srst_i) && !$past(srst_i, 2) && !$past(band_source_select_o)
        |-> vco_band_o == $past(cal_band_i)) else $error("band not the calibration result");
    a_band_manual: assert property ($past(band_source_select_o) && $past(band_source_select_o, 2) &&
        !$past(sle_i, 3) && !$past(srst_i) && !$past(srst_i, 2) && !$past(srst_i, 3) |-> $stable(vco_band_o))
        else $error("manual band followed calibration");
    a_lo_exclusive: assert property (!(lo_port_input_o && lo_port_output_o))
        else $error("lo port both input and output");
    a_lo_in_dbl: assert property (lo_port_input_o |-> lo_port_doubled_o)
        else $error("lo input not doubled");
    a_lo_stable: assert property (!$past(sle_i, 3) && !$past(srst_i)
        && $past(lo_port_select_pin_i) == $past(lo_port_select_pin_i, 2) && !$past(srst_i, 2) && !$past(srst_i, 3)
        |-> $stable({lo_port_input_o, lo_port_output_o, lo_port_doubled_o})) else $error("lo mode moved");
endmodule // smc_assertions

bind smc_config_regs smc_assertions #(.WORD_W(WORD_W), .MON_W(MON_W)) u_chk (
    .clock_i(clock_i), .srst_i(srst_i), .sle_i(sle_i), .lo_port_select_pin_i(lo_port_select_pin_i),
    .cal_band_i(cal_band_i), .monitor_source_i(monitor_source_i), .monitor_select_o(monitor_select_o),
    .monitor_output_pin_o(monitor_output_pin_o), .lo_port_input_o(lo_port_input_o),
    .lo_port_output_o(lo_port_output_o), .lo_port_doubled_o(lo_port_doubled_o), .vco_band_o(vco_band_o),
    .band_source_select_o(band_source_select_o), .vco_enable_o(vco_enable_o), .pump_enable_o(pump_enable_o),
    .pll_powered_down_o(pll_powered_down_o), .dither_restart_o(dither_restart_o),
    .phase_offset_o(phase_offset_o)
);
`default_nettype wire

// file: smc_host_model.sv
`default_nettype none
// ********************************
// serial host
// ********************************
module smc_host_model (
    input wire logic clock_i,
    input wire logic [1:0] slow_i,
    output logic sclk_o,
    output logic sdata_o,
    output logic sle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        sle_o = 1'b1;
    end
    // select code goes out last; a cut frame leaves data bits in the select field
    task automatic send(input logic [23:0] w);
        @(negedge clock_i);
        sle_o = 1'b0;
        for (int b = 23; b >= 0; b--) begin
            @(negedge clock_i);
            sclk_o = 1'b0;
            sdata_o = w[b];
            repeat (slow_i) @(negedge clock_i);
            @(negedge clock_i);
            sclk_o = 1'b1;
        end
        @(negedge clock_i);
        sclk_o = 1'b0;
        sdata_o = ~sdata_o;
        @(negedge clock_i);
        sle_o = 1'b1;
        @(negedge clock_i);
    endtask
endmodule // smc_host_model
`default_nettype wire

// file: smc_tb.sv
`default_nettype none
// ********************************
// testbench
// ********************************
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic pin = 1'b0;
    logic [5:0] cal = 6'h00;
    logic [7:0] msrc = 8'h00;
    logic [1:0] slow = 2'h0;
    wire sclk;
    wire sdata;
    wire sle;
    wire mpin;
    wire [57:0] obs;
    logic [23:0] r [3:6];
    logic [57:0] q_exp [$];
    logic [57:0] q_msk [$];
    logic [57:0] exp_obs;
    int errors = 0;
    int total_checks = 0;
    always #25 clock_i = ~clock_i;
    always @(negedge clock_i) msrc <= 8'($urandom);
    smc_host_model host (.clock_i(clock_i), .slow_i(slow), .sclk_o(sclk), .sdata_o(sdata), .sle_o(sle));
    smc_config_regs #(.WORD_W(24), .MON_W(8)) dut (
        .clock_i(clock_i), .srst_i(srst_i), .sclk_i(sclk), .sdata_i(sdata), .sle_i(sle),
        .lo_port_select_pin_i(pin), .cal_band_i(cal), .monitor_source_i(msrc),
        .dither_magnitude_o(obs[57:55]), .dither_enable_o(obs[54]), .dither_restart_o(obs[53:37]),
        .reference_scale_o(obs[36:35]), .pump_set_resistor_o(obs[34]), .phase_offset_negative_o(obs[33]),
        .phase_offset_o(obs[32:28]), .pump_current_o(obs[27:26]), .monitor_select_o(obs[25:23]),
        .monitor_output_pin_o(mpin), .modulator_output_enable_o(obs[22]), .modulator_bias_enable_o(obs[21]),
        .lo_port_input_o(obs[20]), .lo_port_output_o(obs[19]), .lo_port_doubled_o(obs[18]),
        .pump_enable_o(obs[17]), .vco_enable_o(obs[16:14]), .vco_amplitude_o(obs[13:8]),
        .band_source_select_o(obs[7]), .pll_powered_down_o(obs[6]), .vco_band_o(obs[5:0])
    );
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check_obs(input logic [57:0] got, input logic [57:0] exp, input logic [57:0] msk);
        total_checks++;
        if ((got & msk) !== (exp & msk)) begin
            errors++;
            $display("CHECK FAILED %0t outputs %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t monitor pin %b expected %b", $time, got, exp);
        end
    endtask
    // doubled flag is left open while the port is a disabled output
    task automatic note();
        logic lin;
        logic lout;
        logic [57:0] msk;
        lin = !pin && r[5][4] && !r[5][3];
        lout = !r[5][4] && (pin || r[5][3]);
        msk = {58{1'b1}};
        msk[18] = lin | lout;
        q_msk.push_back(msk);
        q_exp.push_back({r[3][23:3], r[4][20:7], r[5][7:6], lin, lout, lin | r[5][5], r[6][20:17],
            r[6][15:9], r[6][20:17] == 4'h0, r[6][9] ? r[6][8:3] : cal});
    endtask
    task automatic reset_dut();
        srst_i = 1'b1;
        repeat (10) @(negedge clock_i);
        r[3] = 24'h10000B;
        r[4] = 24'h12A7E4;
        r[5] = 24'h0000E5;
        r[6] = 24'h1E2106;
        note();
        srst_i = 1'b0;
        repeat (6) @(negedge clock_i);
    endtask
    task automatic write(input logic [23:0] w);
        host.send(w);
        if (w[2:0] >= 3'h3 && w[2:0] <= 3'h6) begin
            r[w[2:0]] = w;
        end
        note();
        repeat (6) @(negedge clock_i);
    endtask
    task automatic random_writes(input int n);
        for (int i = 0; i < n; i++) begin
            pin = 1'($urandom);
            cal = 6'($urandom);
            slow = 2'($urandom_range(2));
            write(24'($urandom));
        end
    endtask
    initial begin
        @(negedge srst_i);
        forever begin
            repeat (4) @(posedge clock_i);
            #1;
            exp_obs = q_exp.pop_front();
            check_obs(obs, exp_obs, q_msk.pop_front());
            // source is sampled before the next falling edge moves it
            check_pin(mpin, msrc[exp_obs[25:23]]);
            @(posedge sle or negedge srst_i);
        end
    end
    initial begin
        #2000000;
        errors++;
        test_done();
    end
    initial begin
        void'($urandom(32'h5BEE1203));
        reset_dut();
        for (int i = 0; i < 16; i++) begin
            pin = i[3];
            write({16'h0000, i[1], ~i[1], i[2], i[1], i[0], 3'h5});
        end
        write({3'h1, 1'b1, 17'h1FFFF, 3'h3});
        write({3'h0, 1'b1, 17'h00000, 3'h3});
        write({3'h0, 4'h0, 1'b0, 6'h3F, 1'b1, 6'h2A, 3'h6});
        random_writes(20);
        reset_dut();
        random_writes(20);
        test_done();
    end
endmodule // testbench
`default_nettype wire
